// [hdl/alu_bus_if.sv]
interface alu_bus_if;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] res;
  logic       cout;
  modport user (output a, output b, output cin, input res, input cout);
  modport unit (input a, input b, input cin, output res, output cout);
endinterface

// [hdl/alu_pkg.sv]
package alu_pkg;
  typedef enum logic [4:0] {
    OP_IDLE, OP_BR_UGT, OP_BR_ULE, OP_LOAD, OP_MULTIPLY, OP_NEG, OP_OR,
    OP_CCLR, OP_CSET, OP_IEN, OP_IDIS, OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_RIGHT_THROUGH_CARRY, OP_SHIFT_LEFT_ARITH,
    OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITH,
    OP_SUBTRACT_BORROW, OP_SUB, OP_SWAP, OP_TST, OP_TRAP, OP_XOR,
    OP_STACK_POINTER_INIT
  } opcode_t;
  typedef enum logic [1:0] {
    DST_A, DST_X, DST_Y, DST_M
  } dst_t;
  // flag register bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_Z  = 1;
  localparam int FLAG_N  = 2;
  localparam int FLAG_I0 = 3;
  localparam int FLAG_H  = 4;
  localparam int FLAG_I1 = 5;
  localparam logic [7:0] FLAG_RESET = 8'h28;
  localparam logic [1:0] MASK_LEVEL0 = 2'h2;
  localparam logic [1:0] MASK_LEVEL3 = 2'h3;
  localparam logic [7:0] SP_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// [hdl/cpu_alu.sv]
// Functional notes
// - unsigned-greater branch taken only when carry and zero both clear
// - unsigned-lower-or-same branch taken when carry or zero set
// - multiply index by accumulator, product high/low, clear H and C
// - negate gives two's complement, updates N, Z, C
// - carry clear forces C to zero, other flags kept
// - carry set forces C to one, other flags kept
// - interrupt enable loads mask bits with binary 10
// - interrupt disable loads mask bits with binary 11
// - rotate left through carry, old C to bit 0, bit 7 to C
// - rotate right through carry, old C to bit 7, bit 0 to C
// - both left shifts: bit 7 to C, zero in, update N, Z
// - logical right shift: zero in, bit 0 to C, N cleared
// - arithmetic right shift keeps bit 7, bit 0 to C, N, Z
// - nibble swap exchanges halves, updates N and Z
// - subtract with carry: A minus M minus C, updates N, Z, C
// - plain subtract: A minus M, updates N, Z, C
// - inclusive OR into accumulator, updates only N and Z
// - exclusive OR into accumulator, updates N and Z
// - test sets N and Z from operand, writes nothing
// - software trap raises interrupt, sets both mask bits
// - stack pointer reset loads highest permitted value
module cpu_alu
  import alu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       exec_i,
  input  wire opcode_t    op_i,
  input  wire dst_t       dst_i,
  input  wire logic [7:0] mem_i,
  input  wire logic [7:0] offset_i,
  output logic [7:0]      acc_o,
  output logic [7:0]      idx_x_o,
  output logic [7:0]      idx_y_o,
  output logic [7:0]      stack_ptr_o,
  output logic [7:0]      flag_register_o,
  output logic [15:0]     pc_o,
  output logic [7:0]      mem_wdata_o,
  output logic            mem_we_o,
  output logic            sw_irq_o
);

////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  acc;
  logic [7:0]  idx_x;
  logic [7:0]  idx_y;
  logic [7:0]  stack_ptr;
  logic [7:0]  flags;
  logic [15:0] pc;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        sw_irq;

  wire logic       c_in = flags[FLAG_C];
  wire logic       z_in = flags[FLAG_Z];
  // dst selects X or Y for multiply
  wire logic       mult_y = (dst_i == DST_Y);
  // operand source for unary ops
  wire logic [7:0] operand = (dst_i == DST_A) ? acc :
                             (dst_i == DST_X) ? idx_x :
                             (dst_i == DST_Y) ? idx_y : mem_i;
  wire logic [7:0]  mult_idx = mult_y ? idx_y : idx_x;
  wire logic [15:0] product = mult_idx * acc;
  wire logic        take_ugt = ~(c_in | z_in);
  wire logic        take_ule = c_in | z_in;
  wire logic [7:0]  or_res = acc | mem_i;
  wire logic [7:0]  xor_res = acc ^ mem_i;
  wire logic [7:0]  swap_res = {operand[3:0], operand[7:4]};
  wire logic        with_borrow = (op_i == OP_SUBTRACT_BORROW);
  wire logic        neg_op = (op_i == OP_NEG);

////////////////////////////////////////////////////////////////////////////////
  alu_bus_if sub_bus ();
  // negate reuses the subtractor as 0 - operand
  assign sub_bus.a   = neg_op ? BYTE_ZERO : acc;
  assign sub_bus.b   = neg_op ? operand : mem_i;
  assign sub_bus.cin = with_borrow & c_in;

  sub_unit u_sub (
    .bus (sub_bus)
  );

  logic [7:0] shift_res;
  logic       shift_c;

  shift_unit u_shift (
    .op_i   (op_i),
    .val_i  (operand),
    .cin_i  (c_in),
    .res_o  (shift_res),
    .cout_o (shift_c)
  );

////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  result;
  logic        write_res;
  logic [7:0]  next_flags;
  logic [15:0] next_pc;

  always_comb begin
    result     = operand;
    write_res  = 1'b0;
    next_flags = flags;
    next_pc    = pc + 16'h0001;
    case (op_i)
      OP_BR_UGT: begin
        if (take_ugt) next_pc = pc + 16'h0001 + {{8{offset_i[7]}}, offset_i};
      end
      OP_BR_ULE: begin
        if (take_ule) next_pc = pc + 16'h0001 + {{8{offset_i[7]}}, offset_i};
      end
      OP_LOAD: begin
        result = mem_i;
        write_res = 1'b1;
        next_flags[FLAG_N] = mem_i[7];
        next_flags[FLAG_Z] = (mem_i == BYTE_ZERO);
      end
      OP_MULTIPLY: begin
        next_flags[FLAG_H] = 1'b0;
        next_flags[FLAG_C] = 1'b0;
      end
      OP_NEG: begin
        result = sub_bus.res;
        write_res = 1'b1;
        next_flags[FLAG_N] = sub_bus.res[7];
        next_flags[FLAG_Z] = (sub_bus.res == BYTE_ZERO);
        next_flags[FLAG_C] = sub_bus.cout;
      end
      OP_SUB, OP_SUBTRACT_BORROW: begin
        result = sub_bus.res;
        write_res = 1'b1;
        next_flags[FLAG_N] = sub_bus.res[7];
        next_flags[FLAG_Z] = (sub_bus.res == BYTE_ZERO);
        next_flags[FLAG_C] = sub_bus.cout;
      end
      OP_OR, OP_XOR: begin
        result = (op_i == OP_OR) ? or_res : xor_res;
        write_res = 1'b1;
        next_flags[FLAG_N] = result[7];
        next_flags[FLAG_Z] = (result == BYTE_ZERO);
      end
      OP_CCLR: next_flags[FLAG_C] = 1'b0;
      OP_CSET: next_flags[FLAG_C] = 1'b1;
      OP_IEN: begin
        {next_flags[FLAG_I1], next_flags[FLAG_I0]} = MASK_LEVEL0;
      end
      OP_IDIS, OP_TRAP: begin
        {next_flags[FLAG_I1], next_flags[FLAG_I0]} = MASK_LEVEL3;
      end
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY,
      OP_SHIFT_LEFT_ARITH, OP_SHIFT_LEFT_LOGICAL,
      OP_SHIFT_RIGHT_ARITH: begin
        result = shift_res;
        write_res = 1'b1;
        next_flags[FLAG_N] = shift_res[7];
        next_flags[FLAG_Z] = (shift_res == BYTE_ZERO);
        next_flags[FLAG_C] = shift_c;
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        result = shift_res;
        write_res = 1'b1;
        next_flags[FLAG_N] = 1'b0;
        next_flags[FLAG_Z] = (shift_res == BYTE_ZERO);
        next_flags[FLAG_C] = shift_c;
      end
      OP_SWAP: begin
        result = swap_res;
        write_res = 1'b1;
        next_flags[FLAG_N] = swap_res[7];
        next_flags[FLAG_Z] = (swap_res == BYTE_ZERO);
      end
      OP_TST: begin
        next_flags[FLAG_N] = operand[7];
        next_flags[FLAG_Z] = (operand == BYTE_ZERO);
      end
      default: begin
        result = operand;
      end
    endcase
  end

  // two-operand ops always land in the accumulator
  wire logic acc_only = (op_i == OP_SUB) ||
                        (op_i == OP_SUBTRACT_BORROW) ||
                        (op_i == OP_OR) || (op_i == OP_XOR);
  wire dst_t eff_dst  = acc_only ? DST_A : dst_i;

////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc       <= BYTE_ZERO;
      idx_x     <= BYTE_ZERO;
      idx_y     <= BYTE_ZERO;
      stack_ptr <= SP_MAX;
      flags     <= FLAG_RESET;
      pc        <= 16'h0000;
      mem_wdata <= BYTE_ZERO;
      mem_we    <= 1'b0;
      sw_irq    <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      sw_irq <= 1'b0;
      if (exec_i) begin
        flags <= next_flags;
        pc    <= next_pc;
        if (op_i == OP_MULTIPLY) begin
          acc <= product[7:0];
          if (mult_y) idx_y <= product[15:8];
          else idx_x <= product[15:8];
        end else if (write_res) begin
          case (eff_dst)
            DST_A:   acc <= result;
            DST_X:   idx_x <= result;
            DST_Y:   idx_y <= result;
            default: begin
              mem_wdata <= result;
              mem_we    <= 1'b1;
            end
          endcase
        end
        if (op_i == OP_STACK_POINTER_INIT) stack_ptr <= SP_MAX;
        if (op_i == OP_TRAP) sw_irq <= 1'b1;
      end
    end
  end

  assign acc_o           = acc;
  assign idx_x_o         = idx_x;
  assign idx_y_o         = idx_y;
  assign stack_ptr_o     = stack_ptr;
  assign flag_register_o = flags;
  assign pc_o            = pc;
  assign mem_wdata_o     = mem_wdata;
  assign mem_we_o        = mem_we;
  assign sw_irq_o        = sw_irq;

////////////////////////////////////////////////////////////////////////////////
  wire logic run = exec_i && !sys_rst_i;

  default clocking cb_alu @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_exec(opcode_t o);
    run && op_i == o;
  endsequence

  branch_ugt_a: assert property (
    s_exec(OP_BR_UGT) ##0 (c_in || z_in) |=> pc == $past(pc) + 16'h0001)
    else $error("greater branch taken with C or Z set");
  ugt_taken_a: assert property (
    s_exec(OP_BR_UGT) ##0 !(c_in || z_in) |=> pc == $past(pc) + 16'h0001
      + {{8{$past(offset_i[7])}}, $past(offset_i)})
    else $error("greater branch not taken");
  branch_ule_a: assert property (
    s_exec(OP_BR_ULE) ##0 (c_in || z_in) |=> pc == $past(pc) + 16'h0001
      + {{8{$past(offset_i[7])}}, $past(offset_i)})
    else $error("lower-same branch missed");
  ule_skip_a: assert property (
    s_exec(OP_BR_ULE) ##0 !(c_in || z_in) |=> pc == $past(pc) + 16'h0001)
    else $error("lower-same branch taken wrongly");
  mul_flags_a: assert property (
    s_exec(OP_MULTIPLY) |=> !flags[FLAG_C] && !flags[FLAG_H]
      && acc == 8'($past(acc) * $past(mult_idx)))
    else $error("multiply result or flags wrong");
  neg_val_a: assert property (
    s_exec(OP_NEG) ##0 dst_i == DST_A |=> acc == 8'h00 - $past(acc)
      && flags[FLAG_C] == ($past(acc) != 8'h00))
    else $error("negate value wrong");
  carry_clr_a: assert property (
    s_exec(OP_CCLR) |=> flags == ($past(flags) & 8'hFE))
    else $error("carry clear wrong");
  carry_set_a: assert property (
    s_exec(OP_CSET) |=> flags == ($past(flags) | 8'h01))
    else $error("carry set wrong");
  int_en_a: assert property (
    s_exec(OP_IEN) |=> flags[FLAG_I1] && !flags[FLAG_I0])
    else $error("interrupt enable mask wrong");
  int_dis_a: assert property (
    s_exec(OP_IDIS) |=> flags[FLAG_I1] && flags[FLAG_I0])
    else $error("interrupt disable mask wrong");
  rot_left_a: assert property (
    s_exec(OP_ROTATE_LEFT_THROUGH_CARRY) ##0 dst_i == DST_A
      |=> acc == {$past(acc[6:0]), $past(flags[FLAG_C])}
      && flags[FLAG_C] == $past(acc[7]))
    else $error("rotate left through carry wrong");
  rot_right_a: assert property (
    s_exec(OP_ROTATE_RIGHT_THROUGH_CARRY) ##0 dst_i == DST_A
      |=> acc == {$past(flags[FLAG_C]), $past(acc[7:1])}
      && flags[FLAG_C] == $past(acc[0]))
    else $error("rotate right through carry wrong");
  shl_zero_a: assert property (
    run && (op_i == OP_SHIFT_LEFT_ARITH || op_i == OP_SHIFT_LEFT_LOGICAL)
      && dst_i == DST_A |=> acc == {$past(acc[6:0]), 1'b0}
      && flags[FLAG_C] == $past(acc[7]))
    else $error("left shift wrong");
  shr_log_neg_a: assert property (
    s_exec(OP_SHIFT_RIGHT_LOGICAL) |=> !flags[FLAG_N])
    else $error("logical right shift left N set");
  shr_arith_a: assert property (
    s_exec(OP_SHIFT_RIGHT_ARITH) ##0 dst_i == DST_A
      |=> acc == {$past(acc[7]), $past(acc[7:1])}
      && flags[FLAG_C] == $past(acc[0]))
    else $error("arithmetic right shift wrong");
  swap_nib_a: assert property (
    s_exec(OP_SWAP) ##0 dst_i == DST_A
      |=> acc == {$past(acc[3:0]), $past(acc[7:4])}
      && flags[FLAG_N] == acc[7])
    else $error("nibble swap wrong");
  sub_borrow_a: assert property (
    s_exec(OP_SUBTRACT_BORROW)
      |=> acc == $past(acc) - $past(mem_i) - $past(flags[FLAG_C])
      && flags[FLAG_C] == (({1'b0, $past(mem_i)} + $past(flags[FLAG_C]))
        > {1'b0, $past(acc)}))
    else $error("subtract with carry wrong");
  sub_plain_a: assert property (
    s_exec(OP_SUB) |=> acc == $past(acc) - $past(mem_i)
      && flags[FLAG_C] == ($past(mem_i) > $past(acc)))
    else $error("plain subtract wrong");
  or_flags_a: assert property (
    s_exec(OP_OR) |=> acc == ($past(acc) | $past(mem_i))
      && flags[FLAG_C] == $past(flags[FLAG_C]))
    else $error("inclusive or wrong");
  xor_val_a: assert property (
    s_exec(OP_XOR) |=> acc == ($past(acc) ^ $past(mem_i)))
    else $error("exclusive or wrong");
  trap_irq_a: assert property (
    s_exec(OP_TRAP) |=> sw_irq && flags[FLAG_I1] && flags[FLAG_I0])
    else $error("trap did not raise interrupt");
  tst_hold_a: assert property (
    s_exec(OP_TST) |=> !mem_we && $stable(acc) && $stable(idx_x))
    else $error("test wrote a register");
  sp_init_a: assert property (
    s_exec(OP_STACK_POINTER_INIT) |=> stack_ptr == SP_MAX)
    else $error("stack pointer not at maximum");
  idle_hold_a: assert property (
    s_exec(OP_IDLE) |=> $stable(flags) && $stable(acc)
      && pc == $past(pc) + 16'h0001)
    else $error("idle instruction changed state");
endmodule

// [hdl/shift_unit.sv]
module shift_unit
  import alu_pkg::*;
(
  input  wire opcode_t    op_i,
  input  wire logic [7:0] val_i,
  input  wire logic       cin_i,
  output logic [7:0]      res_o,
  output logic            cout_o
);
  always_comb begin
    res_o  = val_i;
    cout_o = cin_i;
    case (op_i)
      OP_ROTATE_LEFT_THROUGH_CARRY: begin
        res_o  = {val_i[6:0], cin_i};
        cout_o = val_i[7];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        res_o  = {cin_i, val_i[7:1]};
        cout_o = val_i[0];
      end
      OP_SHIFT_LEFT_ARITH, OP_SHIFT_LEFT_LOGICAL: begin
        res_o  = {val_i[6:0], 1'b0};
        cout_o = val_i[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res_o  = {1'b0, val_i[7:1]};
        cout_o = val_i[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        res_o  = {val_i[7], val_i[7:1]};
        cout_o = val_i[0];
      end
      default: begin
        res_o  = val_i;
        cout_o = cin_i;
      end
    endcase
  end
endmodule

// [hdl/sub_unit.sv]
module sub_unit (
  alu_bus_if.unit bus
);
  logic [8:0] diff;
  assign diff = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
  assign bus.res  = diff[7:0];
  assign bus.cout = diff[8];
endmodule

// [verification/tb_cpu_instruction_subset_alu.sv]
module tb_cpu_instruction_subset_alu
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        sys_rst_i;
  logic        exec_i;
  opcode_t     op_i;
  dst_t        dst_i;
  logic [7:0]  mem_i;
  logic [7:0]  offset_i;
  logic [7:0]  acc_o;
  logic [7:0]  idx_x_o;
  logic [7:0]  idx_y_o;
  logic [7:0]  stack_ptr_o;
  logic [7:0]  flag_register_o;
  logic [15:0] pc_o;
  logic [7:0]  mem_wdata_o;
  logic        mem_we_o;
  logic        sw_irq_o;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  eacc;
  logic [7:0]  eflags;
  logic [15:0] epc;

  cpu_alu u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .exec_i(exec_i), .op_i(op_i),
    .dst_i(dst_i), .mem_i(mem_i), .offset_i(offset_i), .acc_o(acc_o),
    .idx_x_o(idx_x_o), .idx_y_o(idx_y_o), .stack_ptr_o(stack_ptr_o),
    .flag_register_o(flag_register_o), .pc_o(pc_o),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .sw_irq_o(sw_irq_o)
  );

  always #4 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic check_core();
    chk8(acc_o, eacc);
    chk8(flag_register_o, eflags);
    chk16(pc_o, epc);
  endtask

  // one instruction, inputs launched 1 ns after the edge
  task automatic run(opcode_t op, dst_t d, logic [7:0] m, logic [7:0] off);
    exec_i = 1'b1;
    op_i = op;
    dst_i = d;
    mem_i = m;
    offset_i = off;
    @(posedge clk_i);
    #1;
    epc = epc + 16'h0001;
  endtask

  task automatic nzc(input logic [7:0] v, input logic c);
    eflags[FLAG_N] = v[7];
    eflags[FLAG_Z] = (v == 8'h00);
    eflags[FLAG_C] = c;
  endtask

  task automatic ld(dst_t d, logic [7:0] v);
    run(OP_LOAD, d, v, 8'h00);
    if (d == DST_A) eacc = v;
    nzc(v, eflags[FLAG_C]);
  endtask

  task automatic carry(input logic c);
    run(c ? OP_CSET : OP_CCLR, DST_A, 8'h00, 8'h00);
    eflags[FLAG_C] = c;
  endtask

  task automatic br(opcode_t op, logic [7:0] off, logic taken);
    run(op, DST_A, 8'h00, off);
    if (taken) epc = epc + {{8{off[7]}}, off};
    check_core();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_core();
    chk8(stack_ptr_o, SP_MAX);
    chk8({7'h00, mem_we_o}, 8'h00);
  endtask

  task automatic t_idle_hold();
    ld(DST_A, 8'h81);
    run(OP_IDLE, DST_M, 8'h55, 8'h00);
    check_core();
    chk8({7'h00, mem_we_o}, 8'h00);
    exec_i = 1'b0;
    op_i = OP_CSET;
    @(posedge clk_i);
    #1;
    check_core();
  endtask

  task automatic t_branch();
    carry(1'b1);
    check_core();
    ld(DST_A, 8'h01);
    carry(1'b0);
    check_core();
    br(OP_BR_UGT, 8'h05, 1'b1);
    br(OP_BR_ULE, 8'h05, 1'b0);
    carry(1'b1);
    br(OP_BR_UGT, 8'h05, 1'b0);
    br(OP_BR_ULE, 8'hFE, 1'b1);
    ld(DST_A, 8'h00);
    carry(1'b0);
    br(OP_BR_UGT, 8'h05, 1'b0);
    br(OP_BR_ULE, 8'h03, 1'b1);
  endtask

  task automatic t_mul();
    ld(DST_X, 8'h12);
    ld(DST_A, 8'h34);
    carry(1'b1);
    run(OP_MULTIPLY, DST_X, 8'h00, 8'h00);
    eacc = 8'hA8;
    eflags[FLAG_C] = 1'b0;
    eflags[FLAG_H] = 1'b0;
    check_core();
    chk8(idx_x_o, 8'h03);
    ld(DST_Y, 8'hFF);
    ld(DST_A, 8'hFF);
    run(OP_MULTIPLY, DST_Y, 8'h00, 8'h00);
    eacc = 8'h01;
    check_core();
    chk8(idx_y_o, 8'hFE);
    chk8(idx_x_o, 8'h03);
  endtask

  task automatic t_neg();
    ld(DST_A, 8'h01);
    run(OP_NEG, DST_A, 8'h00, 8'h00);
    eacc = 8'hFF;
    nzc(8'hFF, 1'b1);
    check_core();
    run(OP_NEG, DST_M, 8'h80, 8'h00);
    nzc(8'h80, 1'b1);
    check_core();
    chk8({7'h00, mem_we_o}, 8'h01);
    chk8(mem_wdata_o, 8'h80);
    ld(DST_A, 8'h00);
    chk8({7'h00, mem_we_o}, 8'h00);
    run(OP_NEG, DST_A, 8'h00, 8'h00);
    nzc(8'h00, 1'b0);
    check_core();
  endtask

  task automatic t_mask();
    run(OP_IEN, DST_A, 8'h00, 8'h00);
    eflags[FLAG_I1] = 1'b1;
    eflags[FLAG_I0] = 1'b0;
    check_core();
    run(OP_IDIS, DST_A, 8'h00, 8'h00);
    eflags[FLAG_I0] = 1'b1;
    check_core();
    run(OP_IEN, DST_A, 8'h00, 8'h00);
    run(OP_TRAP, DST_A, 8'h00, 8'h00);
    chk8({7'h00, sw_irq_o}, 8'h01);
    check_core();
    run(OP_STACK_POINTER_INIT, DST_A, 8'h00, 8'h00);
    chk8({7'h00, sw_irq_o}, 8'h00);
    chk8(stack_ptr_o, SP_MAX);
  endtask

  task automatic t_shift();
    opcode_t    op[7] = '{OP_ROTATE_LEFT_THROUGH_CARRY,
                          OP_ROTATE_RIGHT_THROUGH_CARRY,
                          OP_SHIFT_LEFT_ARITH, OP_SHIFT_LEFT_LOGICAL,
                          OP_SHIFT_RIGHT_LOGICAL, OP_SHIFT_RIGHT_ARITH,
                          OP_SWAP};
    logic [7:0] res[7] = '{8'h01, 8'hC0, 8'h00, 8'h00, 8'h40, 8'hC0,
                          8'h08};
    logic       co[7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      ld(DST_A, 8'h80);
      carry(1'b1);
      run(op[i], DST_A, 8'h00, 8'h00);
      eacc = res[i];
      nzc(res[i], co[i]);
      check_core();
    end
  endtask

  task automatic t_arith();
    ld(DST_A, 8'h10);
    carry(1'b1);
    run(OP_SUB, DST_A, 8'h11, 8'h00);
    eacc = 8'hFF;
    nzc(8'hFF, 1'b1);
    check_core();
    run(OP_SUBTRACT_BORROW, DST_A, 8'h0E, 8'h00);
    eacc = 8'hF0;
    nzc(8'hF0, 1'b0);
    check_core();
    run(OP_SUBTRACT_BORROW, DST_A, 8'hF0, 8'h00);
    eacc = 8'h00;
    nzc(8'h00, 1'b0);
    check_core();
    carry(1'b1);
    run(OP_OR, DST_A, 8'h0F, 8'h00);
    eacc = 8'h0F;
    nzc(8'h0F, 1'b1);
    check_core();
    run(OP_XOR, DST_A, 8'h0F, 8'h00);
    eacc = 8'h00;
    nzc(8'h00, 1'b1);
    check_core();
    ld(DST_X, 8'h00);
    ld(DST_A, 8'h80);
    run(OP_TST, DST_X, 8'h00, 8'h00);
    nzc(8'h00, 1'b1);
    check_core();
    chk8(idx_x_o, 8'h00);
    chk8({7'h00, mem_we_o}, 8'h00);
  endtask

  task automatic t_mid_reset();
    sys_rst_i = 1'b1;
    @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    eacc = 8'h00;
    eflags = FLAG_RESET;
    epc = 16'h0000;
    t_reset();
    chk8(idx_y_o, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b1;
    exec_i = 1'b0;
    op_i = OP_IDLE;
    dst_i = DST_A;
    mem_i = 8'h00;
    offset_i = 8'h00;
    eacc = 8'h00;
    eflags = FLAG_RESET;
    epc = 16'h0000;
    repeat (3) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_idle_hold();
    t_branch();
    t_mul();
    t_neg();
    t_mask();
    t_shift();
    t_arith();
    t_mid_reset();
    wrap_up();
  end
endmodule
